// ===== rtl/sfid_params.svh
`ifndef SFID_PARAMS_SVH
`define SFID_PARAMS_SVH
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SFID_OP_MFR_DEV 8'h90
`define SFID_OP_THREE_IDENT 8'h9f
`define SFID_OP_RELEASE 8'hab
`define SFID_OP_DEEP_SLEEP 8'hb9
// ----------------------------------------
// Address values selecting byte order
// ----------------------------------------
`define SFID_ADDR_MFR_FIRST 24'h000000
`define SFID_ADDR_DEV_FIRST 24'h000001
// ----------------------------------------
// Field sizes and counts
// ----------------------------------------
`define SFID_OP_BITS 6'h08
`define SFID_ADDR_END 6'h20
`define SFID_MD_OUT_BITS 5'h10
`define SFID_ID_OUT_BITS 5'h18
// ----------------------------------------
// Delivery state
// ----------------------------------------
`define SFID_ERASED_BYTE 8'hff
`define SFID_STATUS_RESET 8'h00
// ----------------------------------------
// Timing: clock 25 ns
// ----------------------------------------
`define SFID_CLK_PERIOD_NS 25
`define SFID_PUW_MIN_MS 1
`define SFID_PUW_CYCLES ((`SFID_PUW_MIN_MS * 1000000 + \
   `SFID_CLK_PERIOD_NS - 1) / `SFID_CLK_PERIOD_NS)
`define SFID_RES1_MAX_NS 3000
`define SFID_RES1_CYCLES (`SFID_RES1_MAX_NS / `SFID_CLK_PERIOD_NS)
`endif

// ===== rtl/sfid_pkg.sv
`default_nettype none
package sfid_pkg;
   typedef enum logic [4:0] {
      SFID_IDLE = 5'h01,
      SFID_OPCODE = 5'h02,
      SFID_ADDR = 5'h04,
      SFID_SHIFT = 5'h08,
      SFID_IGNORE = 5'h10
   } sfid_state_t;
   typedef struct packed {
      logic selN;
      logic sclk;
      logic serialIn;
   } sfid_pins_t;
   typedef struct packed {
      logic [7:0] mfrId;
      logic [7:0] devId;
      logic [7:0] memType;
      logic [7:0] memCap;
   } sfid_ident_t;
endpackage : sfid_pkg
`default_nettype wire

// ===== rtl/sfid_readout.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfid_params.svh"
module sfid_readout
   import sfid_pkg::*;
#(
   parameter int PUW_CYCLES = `SFID_PUW_CYCLES,
   parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] DEV_ID = 8'h14, // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h20, // Arbitrary value
   parameter logic [7:0] MEM_CAP = 8'h15 // Arbitrary value
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Serial link pins
   input wire logic selN,
   input wire logic sclk,
   input wire logic serial_in,
   output logic serialOut,
   output logic serialOutEn,
   // Device state from other blocks
   input wire logic cycleBusy,
   // Status to other blocks
   output logic deepSleep,
   output logic writeAllowed,
   output logic [7:0] statusOut,
   output logic [7:0] erasedByte
);
   sfid_pins_t pinsSync;
   sfid_pins_t pinsIn;
   logic sclkPrev_reg;
   logic rise;
   logic fall;
   logic selected;
   sfid_state_t state_reg;
   logic [5:0] bitCnt_reg;
   logic [7:0] opcode_reg;
   logic [23:0] addr_reg;
   logic [23:0] shift_reg;
   logic [4:0] outCnt_reg;
   logic [4:0] outLen_reg;
   logic [12:0] resCnt_reg;
   logic releasePend_reg;
   logic [31:0] puwCnt_reg;
   sfid_ident_t ident;

   assign pinsIn = '{selN: selN, sclk: sclk, serialIn: serial_in};
   assign ident = '{mfrId: MFR_ID, devId: DEV_ID, memType: MEM_TYPE,
      memCap: MEM_CAP};

   sfid_sync u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .pinsIn(pinsIn),
      .pinsOut(pinsSync)
   );

   // ----------------------------------------
   // Link clock edge detection
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev_reg <= 1'b0;
      end else begin
         sclkPrev_reg <= pinsSync.sclk;
      end
   end
   assign selected = !pinsSync.selN;
   assign rise = selected && pinsSync.sclk && !sclkPrev_reg;
   assign fall = selected && !pinsSync.sclk && sclkPrev_reg;

   function automatic logic opAccepted(input logic [7:0] op,
         input logic sleeping, input logic busy);
      if (sleeping) begin
         opAccepted = (op == `SFID_OP_RELEASE);
      end else if (busy) begin
         opAccepted = 1'b0;
      end else begin
         opAccepted = (op == `SFID_OP_MFR_DEV) ||
            (op == `SFID_OP_THREE_IDENT);
      end
   endfunction : opAccepted

   // ----------------------------------------
   // Instruction sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SFID_IDLE;
         bitCnt_reg <= 6'h00;
         opcode_reg <= 8'h00;
         addr_reg <= 24'h000000;
      end else if (!selected) begin
         state_reg <= SFID_IDLE;
         bitCnt_reg <= 6'h00;
      end else begin
         case (state_reg)
            SFID_IDLE: begin
               state_reg <= SFID_OPCODE;
               bitCnt_reg <= 6'h00;
            end
            SFID_OPCODE: begin
               if (rise) begin
                  opcode_reg <= {opcode_reg[6:0],
                     pinsSync.serialIn};
                  bitCnt_reg <= bitCnt_reg + 6'h01;
                  if (bitCnt_reg == `SFID_OP_BITS - 6'h01) begin
                     if (!opAccepted({opcode_reg[6:0], pinsSync.serialIn},
                           deepSleep, cycleBusy)) begin
                        state_reg <= SFID_IGNORE;
                     end else if ({opcode_reg[6:0], pinsSync.serialIn} ==
                           `SFID_OP_THREE_IDENT) begin
                        state_reg <= SFID_SHIFT;
                     end else if ({opcode_reg[6:0], pinsSync.serialIn} ==
                           `SFID_OP_MFR_DEV) begin
                        state_reg <= SFID_ADDR;
                     end else begin
                        state_reg <= SFID_IGNORE;
                     end
                  end
               end
            end
            SFID_ADDR: begin
               if (rise) begin
                  addr_reg <= {addr_reg[22:0], pinsSync.serialIn};
                  bitCnt_reg <= bitCnt_reg + 6'h01;
                  if (bitCnt_reg == `SFID_ADDR_END - 6'h01) begin
                     state_reg <= SFID_SHIFT;
                  end
               end
            end
            SFID_SHIFT: begin
               state_reg <= SFID_SHIFT;
            end
            SFID_IGNORE: begin
               state_reg <= SFID_IGNORE;
            end
            default: begin
               state_reg <= SFID_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Output shifter
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= 24'h000000;
         outCnt_reg <= 5'h00;
         outLen_reg <= 5'h00;
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end else if (!selected) begin
         serialOutEn <= 1'b0;
         outCnt_reg <= 5'h00;
      end else if (state_reg == SFID_OPCODE && rise &&
            bitCnt_reg == `SFID_OP_BITS - 6'h01) begin
         shift_reg <= {ident.mfrId, ident.memType, ident.memCap};
         outLen_reg <= `SFID_ID_OUT_BITS;
      end else if (state_reg == SFID_ADDR && rise &&
            bitCnt_reg == `SFID_ADDR_END - 6'h01) begin
         outLen_reg <= `SFID_MD_OUT_BITS;
         if ({addr_reg[22:0], pinsSync.serialIn} == `SFID_ADDR_DEV_FIRST) begin
            shift_reg <= {ident.devId, ident.mfrId, 8'h00};
         end else begin
            shift_reg <= {ident.mfrId, ident.devId, 8'h00};
         end
      end else if (state_reg == SFID_SHIFT && fall) begin
         if (outCnt_reg < outLen_reg) begin
            serialOut <= shift_reg[23];
            serialOutEn <= 1'b1;
            shift_reg <= {shift_reg[22:0], 1'b0};
            outCnt_reg <= outCnt_reg + 5'h01;
         end else begin
            serialOutEn <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Deep sleep and release recovery
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         deepSleep <= 1'b0;
         releasePend_reg <= 1'b0;
         resCnt_reg <= 13'h0000;
      end else begin
         if (state_reg == SFID_OPCODE && rise &&
               bitCnt_reg == `SFID_OP_BITS - 6'h01 && !cycleBusy) begin
            if ({opcode_reg[6:0], pinsSync.serialIn} == `SFID_OP_DEEP_SLEEP &&
                  !deepSleep) begin
               releasePend_reg <= 1'b0;
            end
            if ({opcode_reg[6:0], pinsSync.serialIn} == `SFID_OP_RELEASE &&
                  deepSleep) begin
               releasePend_reg <= 1'b1;
            end
         end
         if (!selected && state_reg != SFID_IDLE && opcode_reg ==
               `SFID_OP_DEEP_SLEEP && !deepSleep && !cycleBusy) begin
            deepSleep <= 1'b1;
         end
         if (releasePend_reg && !selected) begin
            if (resCnt_reg == 13'(`SFID_RES1_CYCLES)) begin
               deepSleep <= 1'b0;
               releasePend_reg <= 1'b0;
               resCnt_reg <= 13'h0000;
            end else begin
               resCnt_reg <= resCnt_reg + 13'h0001;
            end
         end else begin
            resCnt_reg <= 13'h0000;
         end
      end
   end

   // ----------------------------------------
   // Power-up write inhibit and delivery state
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         puwCnt_reg <= 32'h00000000;
         writeAllowed <= 1'b0;
      end else if (puwCnt_reg == 32'(PUW_CYCLES)) begin
         writeAllowed <= 1'b1;
      end else begin
         puwCnt_reg <= puwCnt_reg + 32'h00000001;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         statusOut <= `SFID_STATUS_RESET;
         erasedByte <= `SFID_ERASED_BYTE;
      end else begin
         statusOut <= `SFID_STATUS_RESET;
         erasedByte <= `SFID_ERASED_BYTE;
      end
   end
endmodule : sfid_readout
`default_nettype wire

// ===== rtl/sfid_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfid_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Pins in
   input wire sfid_pkg::sfid_pins_t pinsIn,
   // Synchronised pins
   output sfid_pkg::sfid_pins_t pinsOut
);
   sfid_pkg::sfid_pins_t stage1Reg;
   // ----------------------------------------
   // Two-stage synchroniser, deselected at reset
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stage1Reg <= 3'h4;
         pinsOut <= 3'h4;
      end else begin
         stage1Reg <= pinsIn;
         pinsOut <= stage1Reg;
      end
   end
endmodule : sfid_sync
`default_nettype wire

// ===== verification/serial_flash_id_readout_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_readout_tb_top
   import sfid_pkg::*;
;
   // --------
   // Bench
   // --------
   localparam int PUW = 50;
   localparam logic [7:0] MFR = 8'h5a;
   localparam logic [7:0] DEV = 8'h14;
   localparam logic [7:0] TYP = 8'h20;
   localparam logic [7:0] CAP = 8'h15;
   logic clk_sys, arst_n, cycleBusy, selN, sclk, serial_in;
   logic serialOut, serialOutEn, deepSleep, writeAllowed;
   logic [7:0] statusOut, erasedByte;
   int nMismatch = 0;
   int checksDone = 0;
   sfid_readout #(.PUW_CYCLES(PUW), .MFR_ID(MFR), .DEV_ID(DEV),
      .MEM_TYPE(TYP), .MEM_CAP(CAP)) sfid_readout_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .selN(selN), .sclk(sclk),
      .serial_in(serial_in), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .cycleBusy(cycleBusy),
      .deepSleep(deepSleep), .writeAllowed(writeAllowed),
      .statusOut(statusOut), .erasedByte(erasedByte));
   sfid_host_model sfid_host_model_inst (.clk_sys(clk_sys), .selN(selN),
      .sclk(sclk), .serial_in(serial_in), .serialOut(serialOut),
      .serialOutEn(serialOutEn));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic send(input logic [31:0] b, input int nIn, input int nOut);
      sfid_host_model_inst.frame(b, nIn, nOut);
   endtask : send
   task automatic t_power_up;
      check(writeAllowed, 1'b0);
      check(statusOut, 8'h00);
      check(erasedByte, 8'hff);
      repeat (PUW + 4) @(posedge clk_sys);
      check(writeAllowed, 1'b1);
   endtask : t_power_up
   task automatic t_ident;
      send({8'h9f, 24'h0}, 8, 24);
      check(sfid_host_model_inst.gotBits, {MFR, TYP, CAP});
      check(serialOutEn, 1'b0);
   endtask : t_ident
   task automatic t_mfr_dev;
      send({8'h90, 24'h000000}, 32, 16);
      check(sfid_host_model_inst.gotBits, {8'h00, MFR, DEV});
      send({8'h90, 24'h000001}, 32, 16);
      check(sfid_host_model_inst.gotBits, {8'h00, DEV, MFR});
   endtask : t_mfr_dev
   task automatic t_abort;
      send({8'h9f, 24'h0}, 8, 5);
      check(sfid_host_model_inst.gotBits, {19'h0, MFR[7:3]});
      check(serialOutEn, 1'b0);
      send({8'h90, 24'h000001}, 32, 3);
      check(sfid_host_model_inst.gotBits, {21'h0, DEV[7:5]});
      send({8'h9f, 24'h0}, 8, 24);
      check(sfid_host_model_inst.gotBits, {MFR, TYP, CAP});
   endtask : t_abort
   task automatic t_busy;
      cycleBusy <= 1'b1;
      send({8'h9f, 24'h0}, 8, 24);
      check(sfid_host_model_inst.sawEn, 1'b0);
      cycleBusy <= 1'b0;
   endtask : t_busy
   task automatic t_sleep;
      send({8'hb9, 24'h0}, 8, 0);
      check(deepSleep, 1'b1);
      send({8'h90, 24'h0}, 32, 16);
      check(sfid_host_model_inst.sawEn, 1'b0);
      send({8'hab, 24'h0}, 8, 0);
      repeat (130) @(posedge clk_sys);
      check(deepSleep, 1'b0);
      send({8'h90, 24'h0}, 32, 16);
      check(sfid_host_model_inst.gotBits, {8'h00, MFR, DEV});
   endtask : t_sleep
   initial begin
      arst_n = 1'b0;
      cycleBusy = 1'b0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_power_up;
      t_ident;
      t_mfr_dev;
      t_abort;
      t_busy;
      t_sleep;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      nMismatch++;
      report_and_stop;
   end
endmodule : serial_flash_id_readout_tb_top
`default_nettype wire

// ===== verification/sfid_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfid_host_model (
   // Clock
   input wire logic clk_sys,
   // Link pins
   output logic selN,
   output logic sclk,
   output logic serial_in,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   // --------
   // Frames, link clock idle low
   // --------
   logic [23:0] gotBits;
   logic sawEn;
   initial begin
      selN = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   // No 9Fh is ever sent while the device sleeps
   task automatic frame(input logic [31:0] inBits, input int nIn,
      input int nOut);
      int i;
      gotBits = 24'h0;
      sawEn = 1'b0;
      selN <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (i = 31; i > 31 - nIn; i--) begin
         sclk <= 1'b0;
         serial_in <= inBits[i];
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
      end
      for (i = 0; i < nOut; i++) begin
         sclk <= 1'b0;
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         gotBits = {gotBits[22:0], serialOut};
         sawEn = sawEn | serialOutEn;
      end
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      selN <= 1'b1;
      serial_in <= ~serial_in;
      repeat (8) @(posedge clk_sys);
   endtask : frame
endmodule : sfid_host_model
`default_nettype wire

// ===== verification/sfid_readout_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfid_params.svh"
module sfid_readout_asserts
   import sfid_pkg::*;
#(parameter int PUW_CYCLES = `SFID_PUW_CYCLES) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Link pins
   input wire logic selN,
   input wire logic sclk,
   input wire logic serialOut,
   input wire logic serialOutEn,
   // Device state
   input wire logic cycleBusy,
   input wire logic deepSleep,
   input wire logic writeAllowed,
   input wire logic [7:0] statusOut,
   input wire logic [7:0] erasedByte
);
   // --------
   // Checks
   // --------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   int upCnt_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         upCnt_reg <= 0;
      else if (upCnt_reg < PUW_CYCLES + 4)
         upCnt_reg <= upCnt_reg + 1;
   end
   float_off_a: assert property (selN [*6] |-> !serialOutEn)
      else $error("output enabled while deselected");
   delivery_const_a: assert property (statusOut == 8'h00 &&
      erasedByte == 8'hff) else $error("delivery values wrong");
   busy_quiet_a: assert property (cycleBusy && !serialOutEn |=>
      !serialOutEn) else $error("output while busy");
   sleep_quiet_a: assert property (deepSleep && !serialOutEn |=>
      !serialOutEn) else $error("output while sleeping");
   write_early_a: assert property (upCnt_reg < PUW_CYCLES - 2 |->
      !writeAllowed) else $error("write allowed too early");
   write_late_a: assert property (upCnt_reg > PUW_CYCLES + 2 |->
      writeAllowed) else $error("write still inhibited");
   out_fall_a: assert property (serialOutEn && $changed(serialOut)
      |-> !$past(sclk, 2)) else $error("output changed off falling edge");
   sleep_select_a: assert property ($changed(deepSleep) |->
      selN && $past(selN, 2)) else $error("sleep changed while selected");
   en_select_a: assert property ($rose(serialOutEn) |-> !selN)
      else $error("output enabled without select");
   cover property ($rose(serialOutEn));
   cover property ($rose(deepSleep));
   cover property ($rose(writeAllowed));
endmodule : sfid_readout_asserts
bind sfid_readout sfid_readout_asserts #(.PUW_CYCLES(PUW_CYCLES))
   sfid_readout_asserts_inst (.clk_sys(clk_sys), .arst_n(arst_n),
   .selN(selN), .sclk(sclk), .serialOut(serialOut),
   .serialOutEn(serialOutEn), .cycleBusy(cycleBusy),
   .deepSleep(deepSleep), .writeAllowed(writeAllowed),
   .statusOut(statusOut), .erasedByte(erasedByte));
`default_nettype wire
